// *** design/whip_pkg.sv ***
package whip_pkg;
	// Clock and strobe delay
	localparam int CLK_PERIOD_NS   = 8;
	localparam int STB_DELAY_NS    = 100;
	localparam int STB_DELAY_CYC   = (STB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WORD_W          = 16;
	localparam int BYTE_W          = 8;
	localparam int FIFO_DEPTH      = 16;
	localparam int SUBMODE         = 2'h0;
	localparam logic [WORD_W-1:0] DATA_RST = 16'h0000;

	typedef enum logic [1:0] {
		WHIP_IDLE = 2'b00,
		WHIP_WAIT = 2'b01,
		WHIP_ACK  = 2'b10,
		WHIP_HOLD = 2'b11
	} whip_state_e;
endpackage : whip_pkg

// *** design/whip_fifo.sv ***
`timescale 1ns/1ns
module whip_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             do_wr;
	logic             do_rd;

	always_comb begin
		do_wr = in_valid && in_ready;
		do_rd = out_valid && out_ready;
		next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count;
		if (do_wr && !do_rd) begin
			next_count = count + 1'b1;
		end else if (do_rd && !do_wr) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
endmodule : whip_fifo

// *** design/whip_sync.sv ***
`timescale 1ns/1ns
module whip_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	always_comb begin
		next_meta = async_in;
		next_sync = meta;
	end

	// Resets high so idle active-low lines read inactive
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			meta     <= '1;
			sync_out <= '1;
		end else begin
			meta     <= next_meta;
			sync_out <= next_sync;
		end
	end
endmodule : whip_sync

// *** design/whip_port.sv ***
`timescale 1ns/1ns
// Overview of operation
// - Input word is two byte halves, each double-buffered with interlocked handshake.
// - One active-low strobe latches both halves together.
// - Only the upper half drives acknowledge; lower half acknowledge unused.
// - Every link transfer is one 16-bit word.
// - Local sender puts address-0 byte on bits 15:8, address-1 byte on 7:0.
// - Upper and lower byte lanes are exchanged between the two sides.
// - Data-valid is delayed about 100 ns before acting as the strobe.
// - After the word is latched, acknowledge goes low.
// - Release acknowledge if room remains; else hold low until a word is drained.
// - Acknowledge timed from strobe fall, released regardless of strobe level.
module whip_port #(
	parameter int WIDTH = whip_pkg::WORD_W,
	parameter int DEPTH = whip_pkg::FIFO_DEPTH,
	parameter int DELAY = whip_pkg::STB_DELAY_CYC
) (
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	input  wire logic             data_valid_n,
	input  wire logic [WIDTH-1:0] link_data,
	output logic                  ack_n,
	output logic      [WIDTH-1:0] word_data,
	output logic                  word_valid,
	input  wire logic             word_ready,
	output logic                  overrun
);
	localparam int HW = WIDTH / 2;

	// Byte-lane exchange between the link and the local word
	function automatic logic [WIDTH-1:0] lane_swap(input logic [WIDTH-1:0] w);
		lane_swap = {w[HW-1:0], w[WIDTH-1:HW]};
	endfunction : lane_swap

	logic             dav_s;
	logic [WIDTH-1:0] data_s;
	logic [DELAY-1:0] dly;
	logic [DELAY-1:0] next_dly;
	logic             stb_prev;
	logic             next_stb_prev;
	logic             stb_fall;
	whip_pkg::whip_state_e state;
	whip_pkg::whip_state_e next_state;
	logic [HW-1:0]    upper_half;
	logic [HW-1:0]    lower_half;
	logic [HW-1:0]    next_upper_half;
	logic [HW-1:0]    next_lower_half;
	logic             latched;
	logic             next_latched;
	logic             upper_ack_n;
	logic             next_upper_ack_n;
	logic             lower_ack_n;
	logic             next_lower_ack_n;
	logic             next_overrun;
	logic             f_in_ready;
	logic [WIDTH-1:0] f_out_data;
	logic             f_out_valid;
	logic             hold_valid;
	logic             next_hold_valid;
	logic [WIDTH-1:0] next_word_data;
	logic             next_word_valid;
	logic             f_pop;
	logic [WIDTH-1:0] swapped;

	// Two-flop synchronisers for strobe and data lines
	whip_sync #(.WIDTH(1)) u_sync_dav (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.async_in (data_valid_n),
		.sync_out (dav_s)
	);

	whip_sync #(.WIDTH(WIDTH)) u_sync_data (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.async_in (link_data),
		.sync_out (data_s)
	);

	// Delay line: strobe is data-valid seen DELAY cycles later
	always_comb begin
		next_dly = {dly[DELAY-2:0], dav_s};
		next_stb_prev = dly[DELAY-1];
		stb_fall = stb_prev && !dly[DELAY-1];
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			dly      <= '1;
			stb_prev <= 1'b1;
		end else begin
			dly      <= next_dly;
			stb_prev <= next_stb_prev;
		end
	end

	// Handshake: both halves latch on the one strobe edge
	always_comb begin
		next_state       = state;
		next_upper_half  = upper_half;
		next_lower_half  = lower_half;
		next_latched     = 1'b0;
		next_upper_ack_n = upper_ack_n;
		next_lower_ack_n = lower_ack_n;
		next_overrun     = 1'b0;
		swapped          = lane_swap(data_s);
		case (state)
			whip_pkg::WHIP_IDLE: begin
				if (stb_fall) begin
					// Whole 16-bit word, lanes exchanged
					next_upper_half = swapped[WIDTH-1:HW];
					next_lower_half = swapped[HW-1:0];
					next_state      = whip_pkg::WHIP_WAIT;
				end
			end
			whip_pkg::WHIP_WAIT: begin
				if (f_in_ready) begin
					next_latched     = 1'b1;
					next_upper_ack_n = 1'b0;
					next_lower_ack_n = 1'b0;
					next_state       = whip_pkg::WHIP_ACK;
				end
			end
			whip_pkg::WHIP_ACK: begin
				// The word lands in the FIFO at this edge, so room is judged a cycle later
				if (stb_fall) begin
					next_overrun = 1'b1;
				end
				next_state = whip_pkg::WHIP_HOLD;
			end
			whip_pkg::WHIP_HOLD: begin
				if (stb_fall) begin
					next_overrun = 1'b1;
				end
				if (f_in_ready) begin
					next_upper_ack_n = 1'b1;
					next_lower_ack_n = 1'b1;
					next_state       = whip_pkg::WHIP_IDLE;
				end
			end
			default: begin
				next_state = whip_pkg::WHIP_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state       <= whip_pkg::WHIP_IDLE;
			upper_half  <= '0;
			lower_half  <= '0;
			latched     <= 1'b0;
			upper_ack_n <= 1'b1;
			lower_ack_n <= 1'b1;
			overrun     <= 1'b0;
		end else begin
			state       <= next_state;
			upper_half  <= next_upper_half;
			lower_half  <= next_lower_half;
			latched     <= next_latched;
			upper_ack_n <= next_upper_ack_n;
			lower_ack_n <= next_lower_ack_n;
			overrun     <= next_overrun;
		end
	end

	// Only the upper half answers the sender; lower ack left unused
	assign ack_n = upper_ack_n;

	whip_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.in_data   ({upper_half, lower_half}),
		.in_valid  (latched),
		.in_ready  (f_in_ready),
		.out_data  (f_out_data),
		.out_valid (f_out_valid),
		.out_ready (f_pop)
	);

	// Registered output stage so outputs come from flops
	always_comb begin
		f_pop           = f_out_valid && (!hold_valid || word_ready);
		next_hold_valid = hold_valid;
		next_word_data  = word_data;
		if (f_pop) begin
			next_hold_valid = 1'b1;
			next_word_data  = f_out_data;
		end else if (word_ready) begin
			next_hold_valid = 1'b0;
		end
		next_word_valid = next_hold_valid;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hold_valid <= 1'b0;
			word_data  <= whip_pkg::DATA_RST;
			word_valid <= 1'b0;
		end else begin
			hold_valid <= next_hold_valid;
			word_data  <= next_word_data;
			word_valid <= next_word_valid;
		end
	end
endmodule : whip_port

// *** sim/whip_chk.sv ***
`timescale 1ns/1ns
module whip_chk #(
	parameter int WIDTH = 16
) (
	input wire logic             sys_clk,
	input wire logic             resetn,
	input wire logic             data_valid_n,
	input wire logic [WIDTH-1:0] link_data,
	input wire logic             ack_n,
	input wire logic [WIDTH-1:0] word_data,
	input wire logic             word_valid,
	input wire logic             word_ready,
	input wire logic             overrun
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	AST_ACK_QUIET: assert property ($fell(data_valid_n) && ack_n |-> ack_n[*8] ##1 ack_n[*5])
		else $error("ack before strobe delay");
	AST_ACK_LATE: assert property ($fell(data_valid_n) && ack_n && !word_valid |-> ##[13:24] !ack_n)
		else $error("ack missing after strobe");
	AST_ACK_PULSE: assert property ($fell(ack_n) && !word_valid |=> !ack_n ##1 ack_n)
		else $error("ack not released with room");
	AST_ACK_HOLD: assert property (!ack_n [*3] |-> word_valid)
		else $error("ack held without full buffer");
	AST_PUSH: assert property ($fell(ack_n) |-> ##[0:4] word_valid)
		else $error("no word after ack");
	AST_WORD_HOLD: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
		else $error("word lost before accept");
	AST_OVR_CAUSE: assert property (overrun |-> !$past(ack_n))
		else $error("overrun without held ack");
	AST_OVR_PULSE: assert property (overrun |=> !overrun)
		else $error("overrun longer than one cycle");
	cover property ($fell(ack_n) ##1 ack_n);
	cover property (!ack_n [*8]);
	cover property (overrun);
endmodule : whip_chk

bind whip_port whip_chk #(.WIDTH(WIDTH)) u_chk (
	.sys_clk(sys_clk), .resetn(resetn), .data_valid_n(data_valid_n), .link_data(link_data),
	.ack_n(ack_n), .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
	.overrun(overrun));

// *** sim/whip_sender.sv ***
`timescale 1ns/1ns
module whip_sender (
	input  wire logic        sys_clk,
	input  wire logic        ack_n,
	output logic             data_valid_n,
	output logic      [15:0] link_data
);
	initial begin
		data_valid_n = 1'b1;
		link_data    = 16'h0000;
	end
	// Rude mode ignores the acknowledge and holds the strobe low for a fixed span
	task automatic send(input logic [15:0] w, input int gap, input bit rude);
		int i;
		i = 0;
		@(posedge sys_clk);
		link_data <= w;
		repeat (9) @(posedge sys_clk);
		data_valid_n <= 1'b0;
		while ((ack_n || rude) && i < 30) begin
			@(posedge sys_clk);
			i++;
		end
		data_valid_n <= 1'b1;
		link_data    <= ~w;
		repeat (gap + 3) @(posedge sys_clk);
	endtask : send
endmodule : whip_sender

// *** sim/whip_port_test.sv ***
`timescale 1ns/1ns
module whip_port_test;
	logic        sys_clk;
	logic        resetn;
	logic        data_valid_n;
	logic [15:0] link_data;
	logic        ack_n;
	logic [15:0] word_data;
	logic        word_valid;
	logic        word_ready;
	logic        overrun;
	logic        rdy_en;
	int          n_fail;
	int          cmp_count;
	int          n_ovr;
	logic [15:0] exp_q[$];

	whip_port u_dut (
		.sys_clk(sys_clk), .resetn(resetn), .data_valid_n(data_valid_n),
		.link_data(link_data), .ack_n(ack_n), .word_data(word_data),
		.word_valid(word_valid), .word_ready(word_ready), .overrun(overrun));
	whip_sender u_snd (
		.sys_clk(sys_clk), .ack_n(ack_n), .data_valid_n(data_valid_n), .link_data(link_data));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic conclude;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	// Model holds 17 words at most; a word sent while full is refused
	task automatic xfer(input int gap, input bit rude);
		logic [15:0] w;
		w = 16'($urandom);
		if (exp_q.size() < 17)
			exp_q.push_back({w[7:0], w[15:8]});
		u_snd.send(w, gap, rude);
	endtask : xfer

	always @(posedge sys_clk) begin
		word_ready <= rdy_en && ($urandom % 4 != 0);
		if (overrun === 1'b1)
			n_ovr++;
		if ((word_valid && word_ready) === 1'b1)
			check("word_data", exp_q.size() ? exp_q.pop_front() : ~word_data, word_data);
	end

	initial begin
		resetn     = 1'b0;
		rdy_en     = 1'b0;
		word_ready = 1'b0;
		n_fail     = 0;
		cmp_count  = 0;
		n_ovr      = 0;
		void'($urandom(54769));
		repeat (16) @(posedge sys_clk);
		check("ack_n", 16'h0001, {15'h0, ack_n});
		resetn <= 1'b1;
		rdy_en <= 1'b1;
		for (int k = 0; k < 20; k++)
			xfer(k % 4, 1'b0);
		repeat (30) @(posedge sys_clk);
		rdy_en <= 1'b0;
		repeat (40) @(posedge sys_clk);
		check("pending", 16'h0000, 16'(exp_q.size()));
		for (int k = 0; k < 17; k++)
			xfer(0, 1'b0);
		xfer(0, 1'b1);
		check("ack_n", 16'h0000, {15'h0, ack_n});
		check("overrun", 16'h0001, 16'(n_ovr));
		rdy_en <= 1'b1;
		repeat (100) @(posedge sys_clk);
		check("ack_n", 16'h0001, {15'h0, ack_n});
		xfer(2, 1'b0);
		repeat (40) @(posedge sys_clk);
		check("pending", 16'h0000, 16'(exp_q.size()));
		conclude();
	end

	// The whole run needs about 1500 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		conclude();
	end
endmodule : whip_port_test
